// [vxi_defs.svh]
`ifndef VXI_DEFS_SVH
`define VXI_DEFS_SVH

// ---------------------------------------------------------------
// Field selectors for the field-read and field-write ports
// ---------------------------------------------------------------
`define VXI_SEL_W 4
`define VXI_SEL_EVT_INFO 4'h0
`define VXI_SEL_EVT_ERR 4'h1
`define VXI_SEL_INSN_LEN 4'h2
`define VXI_SEL_LIN_ADDR 4'h3
`define VXI_SEL_OPND_INFO 4'h4
`define VXI_SEL_IO_COUNT 4'h5
`define VXI_SEL_IO_SRC 4'h6
`define VXI_SEL_IO_DST 4'h7
`define VXI_SEL_IO_IP 4'h8
`define VXI_SEL_INSN_ERR 4'h9

// ---------------------------------------------------------------
// Event-delivery information layout
// ---------------------------------------------------------------
`define VXI_EVT_VALID_BIT 31
`define VXI_EVT_RSVD_W 18
`define VXI_TYPE_EXT_INT 3'h0
`define VXI_TYPE_NMI 3'h2
`define VXI_TYPE_HW_EXC 3'h3
`define VXI_TYPE_SW_INT 3'h4
`define VXI_TYPE_PRIV_SW_EXC 3'h5
`define VXI_TYPE_SW_EXC 3'h6

// ---------------------------------------------------------------
// Operand descriptor layout and sizing
// ---------------------------------------------------------------
`define VXI_OPND_RSVD_HI_W 4
`define VXI_ADDR_16 3'h0
`define VXI_ADDR_32 3'h1
`define VXI_ADDR_64 3'h2
`define VXI_EXT64 1'b1
`define VXI_RESET_32 32'h0000_0000
`define VXI_RESET_64 64'h0000_0000_0000_0000

`endif

// [vxi_pkg.sv]
package vxi_pkg;

  // Virtualization-management instruction that caused the exit
  typedef enum logic [2:0] {
    VXI_INSN_CLEAR,
    VXI_INSN_PTR_LOAD,
    VXI_INSN_PTR_STORE,
    VXI_INSN_FIELD_READ,
    VXI_INSN_FIELD_WRITE,
    VXI_INSN_ENABLE
  } vxi_virt_insn_t;

  // Why the guest was left; several flags may be set together
  typedef struct packed {
    logic during_delivery;
    logic insn_exit;
    logic virt_insn_exit;
    logic msw_load_mem;
    logic string_port_io;
    logic smi_after_io;
  } vxi_exit_cause_t;

  // Event that was being delivered when the exit hit
  typedef struct packed {
    logic [7:0] vector;
    logic [2:0] ev_type;
    logic err_valid;
    logic [31:0] err_code;
  } vxi_event_t;

  // Decoded operand of a virtualization-management instruction
  typedef struct packed {
    logic [1:0] scale;
    logic [3:0] first_register_operand;
    logic [2:0] addr_size;
    logic is_reg;
    logic [2:0] segment;
    logic [3:0] index_register_field;
    logic index_invalid;
    logic [3:0] base_register_field;
    logic base_invalid;
    logic [3:0] second_register_operand;
  } vxi_operand_t;

  // Register values as they stood before the I/O instruction
  typedef struct packed {
    logic [63:0] count_register;
    logic [63:0] source_index_register;
    logic [63:0] dest_index_register;
    logic [63:0] instruction_pointer;
  } vxi_io_regs_t;

endpackage : vxi_pkg

// [vxi_event_pack.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vxi_defs.svh"

module vxi_event_pack
  import vxi_pkg::*;
(
  input wire vxi_event_t event_i,
  output logic [31:0] info_o,
  output logic keep_err_o
);

  // ---------------------------------------------------------------
  // Pack the event word; bit 12 and reserved bits go out as zero
  // ---------------------------------------------------------------
  always_comb
  begin
    info_o = {1'b1, {`VXI_EVT_RSVD_W{1'b0}}, 1'b0,
              event_i.err_valid, event_i.ev_type,
              event_i.vector};
  end

  // Error code is kept only for a hardware exception that pushes one
  assign keep_err_o = event_i.err_valid &&
                      (event_i.ev_type == `VXI_TYPE_HW_EXC);

endmodule : vxi_event_pack
`default_nettype wire

// [vxi_operand_pack.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vxi_defs.svh"

module vxi_operand_pack
  import vxi_pkg::*;
(
  input wire vxi_virt_insn_t insn_i,
  input wire vxi_operand_t opnd_i,
  output logic [31:0] info_o
);

  logic mem_only;
  logic is_reg;

  // ---------------------------------------------------------------
  // Four instructions only take memory operands
  // ---------------------------------------------------------------
  assign mem_only = (insn_i != VXI_INSN_FIELD_READ) &&
                    (insn_i != VXI_INSN_FIELD_WRITE);
  assign is_reg = opnd_i.is_reg && !mem_only;

  // Undefined fields are driven as zero so the word is repeatable
  always_comb
  begin
    info_o = 32'h0000_0000;
    info_o[10] = is_reg;
    if (is_reg)
    begin
      info_o[6:3] = opnd_i.first_register_operand;
    end
    else
    begin
      if (!opnd_i.index_invalid)
      begin
        info_o[1:0] = opnd_i.scale;
        info_o[21:18] = opnd_i.index_register_field;
      end
      info_o[9:7] = opnd_i.addr_size;
      info_o[17:15] = opnd_i.segment;
      info_o[22] = opnd_i.index_invalid;
      if (!opnd_i.base_invalid)
      begin
        info_o[26:23] = opnd_i.base_register_field;
      end
      info_o[27] = opnd_i.base_invalid;
    end
    if (!mem_only)
    begin
      info_o[31:28] = opnd_i.second_register_operand;
    end
  end

endmodule : vxi_operand_pack
`default_nettype wire

// [vxi_exit_info.sv]
// How it works
// - Vector goes to event info bits 7:0
// - Event type encoded in bits 10:8
// - Bit 11 flags a valid error code
// - Delivery exit fills info, sets bit 31
// - Pushed hardware error code copied to register
// - Injected events recorded like any other
// - Instruction exits store instruction length
// - Length also kept for software interrupt and software exception delivery
// - Linear address for msw, string, smi
// - Virtualization instructions get operand descriptor
// - Bits 1:0 index scaling
// - Bits 6:3 first register operand
// - Bits 9:7 address size
// - Bit 10 register flag, memory-only cleared
// - Bits 17:15 segment register
// - Index register and its invalid bit
// - Base register and its invalid bit
// - Bits 31:28 second register operand
// - Reserved bits written as zero
// - I/O snapshots only on smi after I/O
// - Exits never touch instruction error register
// - Error register updated by error report only
// - Field writes to exit info rejected
`timescale 1ns/1ps
`default_nettype none
`include "vxi_defs.svh"

module vxi_exit_info
  import vxi_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic exit_valid_i,
  input wire vxi_exit_cause_t exit_cause_i,
  input wire vxi_event_t event_i,
  input wire logic [3:0] insn_len_i,
  input wire logic [63:0] lin_addr_i,
  input wire vxi_virt_insn_t virt_insn_i,
  input wire vxi_operand_t operand_i,
  input wire vxi_io_regs_t io_regs_i,
  input wire logic err_report_i,
  input wire logic [31:0] err_code_i,
  input wire logic rd_req_i,
  input wire logic [`VXI_SEL_W-1:0] rd_sel_i,
  input wire logic wr_req_i,
  input wire logic [`VXI_SEL_W-1:0] wr_sel_i,
  output logic rd_ack_o,
  output logic rd_fail_o,
  output logic [63:0] rd_data_o,
  output logic wr_fail_o,
  output logic event_valid_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Natural-width value: upper half is zero without the 64-bit mode
  function automatic logic [63:0] nat_width(input logic [63:0] v);
    logic [63:0] r;
    r = v;
    if (!`VXI_EXT64)
    begin
      r[63:32] = 32'h0000_0000;
    end
    return r;
  endfunction : nat_width

  // Decode of a selector into "is one of our fields"
  function automatic logic sel_mapped(input logic [`VXI_SEL_W-1:0] s);
    return s <= `VXI_SEL_INSN_ERR;
  endfunction : sel_mapped

  // Read data is 64 bits; 32-bit fields go out with a zero upper half
  function automatic logic [63:0] zext32(input logic [31:0] v);
    return {32'h0000_0000, v};
  endfunction : zext32

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] event_delivery_info_reg;
  logic [31:0] event_delivery_error_code_reg;
  logic [31:0] exit_insn_length_reg;
  logic [63:0] guest_linear_addr_reg;
  logic [31:0] virt_insn_operand_info_reg;
  logic [63:0] io_count_snapshot_reg;
  logic [63:0] io_source_index_snapshot_reg;
  logic [63:0] io_dest_index_snapshot_reg;
  logic [63:0] io_insn_pointer_snapshot_reg;
  logic [31:0] virt_insn_error_reg;

  logic [31:0] evt_word;
  logic keep_err;
  logic [31:0] opnd_word;
  logic sw_event;
  logic [63:0] rd_data_next;

  // ---------------------------------------------------------------
  // Packers
  // ---------------------------------------------------------------

  // Injected and natural events arrive on the same port
  vxi_event_pack u_event_pack (
    .event_i(event_i),
    .info_o(evt_word),
    .keep_err_o(keep_err)
  );

  vxi_operand_pack u_operand_pack (
    .insn_i(virt_insn_i),
    .opnd_i(operand_i),
    .info_o(opnd_word)
  );

  // Software interrupts and software exceptions carry an instruction length
  assign sw_event = exit_cause_i.during_delivery &&
                    ((event_i.ev_type == `VXI_TYPE_SW_INT) ||
                     (event_i.ev_type == `VXI_TYPE_SW_EXC));

  // ---------------------------------------------------------------
  // Event-delivery information
  // ---------------------------------------------------------------

  // Cleared word on a plain exit so the valid bit reads zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      event_delivery_info_reg <= `VXI_RESET_32;
    end
    else if (exit_valid_i)
    begin
      if (exit_cause_i.during_delivery)
      begin
        event_delivery_info_reg <= evt_word;
      end
      else
      begin
        event_delivery_info_reg <= `VXI_RESET_32;
      end
    end
  end

  // Error code only when the exception would have pushed one
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      event_delivery_error_code_reg <= `VXI_RESET_32;
    end
    else if (exit_valid_i && exit_cause_i.during_delivery && keep_err)
    begin
      event_delivery_error_code_reg <= event_i.err_code;
    end
  end

  // Mirror of the valid bit for the core's exit handler
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      event_valid_o <= 1'b0;
    end
    else if (exit_valid_i)
    begin
      event_valid_o <= exit_cause_i.during_delivery;
    end
  end

  // ---------------------------------------------------------------
  // Instruction-caused information
  // ---------------------------------------------------------------

  // Length zero-extended to the 32-bit field
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      exit_insn_length_reg <= `VXI_RESET_32;
    end
    else if (exit_valid_i && (exit_cause_i.insn_exit || sw_event))
    begin
      exit_insn_length_reg <= {28'h000_0000, insn_len_i};
    end
  end

  // Linear address for the three cases that need one
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      guest_linear_addr_reg <= `VXI_RESET_64;
    end
    else if (exit_valid_i && (exit_cause_i.msw_load_mem ||
                              exit_cause_i.string_port_io ||
                              exit_cause_i.smi_after_io))
    begin
      guest_linear_addr_reg <= nat_width(lin_addr_i);
    end
  end

  // Operand descriptor for the six virtualization instructions
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      virt_insn_operand_info_reg <= `VXI_RESET_32;
    end
    else if (exit_valid_i && exit_cause_i.virt_insn_exit)
    begin
      virt_insn_operand_info_reg <= opnd_word;
    end
  end

  // ---------------------------------------------------------------
  // I/O register snapshots
  // ---------------------------------------------------------------

  // Other exits leave the last snapshot in place
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_count_snapshot_reg <= `VXI_RESET_64;
      io_source_index_snapshot_reg <= `VXI_RESET_64;
      io_dest_index_snapshot_reg <= `VXI_RESET_64;
      io_insn_pointer_snapshot_reg <= `VXI_RESET_64;
    end
    else if (exit_valid_i && exit_cause_i.smi_after_io)
    begin
      io_count_snapshot_reg <=
        nat_width(io_regs_i.count_register);
      io_source_index_snapshot_reg <=
        nat_width(io_regs_i.source_index_register);
      io_dest_index_snapshot_reg <=
        nat_width(io_regs_i.dest_index_register);
      io_insn_pointer_snapshot_reg <=
        nat_width(io_regs_i.instruction_pointer);
    end
  end

  // ---------------------------------------------------------------
  // Instruction-error register
  // ---------------------------------------------------------------

  // Deliberately blind to exit_valid_i; only error reports write it
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      virt_insn_error_reg <= `VXI_RESET_32;
    end
    else if (err_report_i)
    begin
      virt_insn_error_reg <= err_code_i;
    end
  end

  // ---------------------------------------------------------------
  // Field-read port
  // ---------------------------------------------------------------

  // Mux of stored fields; values persist between exits
  always_comb
  begin
    rd_data_next = `VXI_RESET_64;
    case (rd_sel_i)
      `VXI_SEL_EVT_INFO:
        rd_data_next = zext32(event_delivery_info_reg);
      `VXI_SEL_EVT_ERR:
        rd_data_next = zext32(event_delivery_error_code_reg);
      `VXI_SEL_INSN_LEN:
        rd_data_next = zext32(exit_insn_length_reg);
      `VXI_SEL_LIN_ADDR:
        rd_data_next = guest_linear_addr_reg;
      `VXI_SEL_OPND_INFO:
        rd_data_next = zext32(virt_insn_operand_info_reg);
      `VXI_SEL_IO_COUNT:
        rd_data_next = io_count_snapshot_reg;
      `VXI_SEL_IO_SRC:
        rd_data_next = io_source_index_snapshot_reg;
      `VXI_SEL_IO_DST:
        rd_data_next = io_dest_index_snapshot_reg;
      `VXI_SEL_IO_IP:
        rd_data_next = io_insn_pointer_snapshot_reg;
      `VXI_SEL_INSN_ERR:
        rd_data_next = zext32(virt_insn_error_reg);
      default:
        rd_data_next = `VXI_RESET_64;
    endcase
  end

  // One-cycle answer; an unknown selector fails with zero data
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_ack_o <= 1'b0;
      rd_fail_o <= 1'b0;
      rd_data_o <= `VXI_RESET_64;
    end
    else
    begin
      rd_ack_o <= rd_req_i && sel_mapped(rd_sel_i);
      rd_fail_o <= rd_req_i && !sel_mapped(rd_sel_i);
      if (rd_req_i)
      begin
        rd_data_o <= rd_data_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Field-write port
  // ---------------------------------------------------------------

  // Every field here is read-only, so any write attempt fails;
  // the selector is not even decoded, nothing can leak through
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_fail_o <= 1'b0;
    end
    else
    begin
      wr_fail_o <= wr_req_i;
    end
  end

  // ---------------------------------------------------------------
  // Unused inputs
  // ---------------------------------------------------------------

  // Selector kept for port symmetry only
  logic unused_wr_sel;
  assign unused_wr_sel = ^wr_sel_i;

endmodule : vxi_exit_info
`default_nettype wire

// [vxi_exit_info_sva.sv]
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------
// Exit information checker
// --------------------------------------------------
module vxi_exit_info_sva
  import vxi_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic exit_valid_i,
  input wire vxi_exit_cause_t exit_cause_i,
  input wire vxi_event_t event_i,
  input wire logic [3:0] insn_len_i,
  input wire logic [63:0] lin_addr_i,
  input wire vxi_virt_insn_t virt_insn_i,
  input wire vxi_operand_t operand_i,
  input wire vxi_io_regs_t io_regs_i,
  input wire logic err_report_i,
  input wire logic [31:0] err_code_i,
  input wire logic rd_req_i,
  input wire logic [3:0] rd_sel_i,
  input wire logic wr_req_i,
  input wire logic [3:0] wr_sel_i,
  input wire logic rd_ack_o,
  input wire logic rd_fail_o,
  input wire logic [63:0] rd_data_o,
  input wire logic wr_fail_o,
  input wire logic event_valid_o
);
  // Single domain, so one clock and one reset serve all
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // Exit kinds and the read that follows them
  sequence dlv_exit_s;
    exit_valid_i && exit_cause_i.during_delivery;
  endsequence
  sequence plain_exit_s;
    exit_valid_i && !exit_cause_i.during_delivery;
  endsequence
  sequence info_rd_s;
    rd_req_i && rd_sel_i == 4'h0 && !exit_valid_i;
  endsequence

  evt_info_set_a:
    assert property (dlv_exit_s ##1 info_rd_s |=> rd_data_o[31] &&
      rd_data_o[30:13] == 18'h0 && rd_data_o[63:32] == 32'h0)
    else $error("event info not marked valid");
  evt_info_clear_a:
    assert property (plain_exit_s ##1 info_rd_s |=> rd_data_o == 64'h0)
    else $error("event info not cleared");
  evt_flag_set_a:
    assert property (dlv_exit_s |=> event_valid_o)
    else $error("event valid flag not set");
  evt_flag_clr_a:
    assert property (plain_exit_s |=> !event_valid_o)
    else $error("event valid flag not cleared");
  evt_flag_hold_a:
    assert property (!exit_valid_i |=> $stable(event_valid_o))
    else $error("event valid flag moved without exit");
  rd_answer_a:
    assert property (rd_req_i && rd_sel_i <= 4'h9 |=> rd_ack_o && !rd_fail_o)
    else $error("mapped read not acknowledged");
  rd_refuse_a:
    assert property (rd_req_i && rd_sel_i > 4'h9 |=>
      rd_fail_o && !rd_ack_o && rd_data_o == 64'h0)
    else $error("unmapped read not refused");
  rd_quiet_a:
    assert property (!rd_req_i |=> !rd_ack_o && !rd_fail_o &&
      $stable(rd_data_o))
    else $error("read outputs moved without request");
  wr_refuse_a:
    assert property (wr_req_i |=> wr_fail_o)
    else $error("field write not rejected");
  wr_quiet_a:
    assert property (!wr_req_i |=> !wr_fail_o)
    else $error("write failure without request");
  err_update_a:
    assert property (err_report_i ##1 (rd_req_i && rd_sel_i == 4'h9 &&
      !err_report_i) |=> rd_data_o == {32'h0, $past(err_code_i, 2)})
    else $error("error report not recorded");
endmodule : vxi_exit_info_sva

// Attach beside every instance of the exit information block
bind vxi_exit_info vxi_exit_info_sva u_sva (.clk_sys_i, .rst_n_i,
  .exit_valid_i, .exit_cause_i, .event_i, .insn_len_i, .lin_addr_i,
  .virt_insn_i, .operand_i, .io_regs_i, .err_report_i, .err_code_i,
  .rd_req_i, .rd_sel_i, .wr_req_i, .wr_sel_i, .rd_ack_o, .rd_fail_o,
  .rd_data_o, .wr_fail_o, .event_valid_o);

`default_nettype wire

// [vxi_exit_info_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------
// Exit information testbench
// --------------------------------------------------
module vxi_exit_info_tb_top
  import vxi_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic exit_valid_i = 1'b0;
  vxi_exit_cause_t exit_cause_i = '0;
  vxi_event_t event_i = '0;
  logic [3:0] insn_len_i = 4'h0;
  logic [63:0] lin_addr_i = 64'h0;
  vxi_virt_insn_t virt_insn_i = VXI_INSN_CLEAR;
  vxi_operand_t operand_i = '0;
  vxi_io_regs_t io_regs_i = '0;
  logic err_report_i = 1'b0;
  logic [31:0] err_code_i = 32'h0;
  logic rd_req_i = 1'b0;
  logic [3:0] rd_sel_i = 4'h0;
  logic wr_req_i = 1'b0;
  logic [3:0] wr_sel_i = 4'h0;
  logic rd_ack_o;
  logic rd_fail_o;
  logic [63:0] rd_data_o;
  logic wr_fail_o;
  logic event_valid_o;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  logic [31:0] e_err;
  logic [31:0] e_len;
  logic [255:0] ior;
  logic [2:0] ty [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};

  vxi_exit_info u_dut (.clk_sys_i, .rst_n_i, .exit_valid_i, .exit_cause_i,
    .event_i, .insn_len_i, .lin_addr_i, .virt_insn_i, .operand_i,
    .io_regs_i, .err_report_i, .err_code_i, .rd_req_i, .rd_sel_i,
    .wr_req_i, .wr_sel_i, .rd_ack_o, .rd_fail_o, .rd_data_o, .wr_fail_o,
    .event_valid_o);

  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;

  // Hang guard, far above the roughly 155 cycles needed
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      summarize();
    end
  end

  task summarize;
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Exit pulse; the caller follows it with a read, never another exit
  task ex(input vxi_exit_cause_t c);
    exit_cause_i <= c;
    exit_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    exit_valid_i <= 1'b0;
  endtask : ex

  // Read one field; answer and data are looked at after the edge settles
  task rd(input logic [3:0] s, input logic [63:0] e);
    rd_req_i <= 1'b1;
    rd_sel_i <= s;
    @(posedge clk_sys_i);
    rd_req_i <= 1'b0;
    #1;
    chk(64'({rd_ack_o, rd_fail_o}), (s > 4'h9) ? 64'h1 : 64'h2);
    chk(rd_data_o, e);
    @(posedge clk_sys_i);
  endtask : rd

  task wr(input logic [3:0] s);
    wr_req_i <= 1'b1;
    wr_sel_i <= s;
    @(posedge clk_sys_i);
    wr_req_i <= 1'b0;
    #1;
    chk(64'(wr_fail_o), 64'h1);
    @(posedge clk_sys_i);
  endtask : wr

  // Main sequence
  initial
  begin
    e_err = 32'h0;
    e_len = 32'h0;
    ior = {64'h0011_2233_4455_6677, 64'h8899_AABB_CCDD_EEFF,
           64'hF0E1_D2C3_B4A5_9687, 64'h7869_5A4B_3C2D_1E0F};
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 16; i++)
      rd(i[3:0], 64'h0);
    for (i = 0; i < 6; i++)
    begin
      event_i.vector <= 8'h40 + 8'(i);
      event_i.ev_type <= ty[i];
      event_i.err_valid <= (i != 1);
      event_i.err_code <= 32'hE000_0000 + 32'(i);
      insn_len_i <= 4'h3 + 4'(i);
      ex(6'h20);
      if (ty[i] == 3'h3)
        e_err = 32'hE000_0000 + 32'(i);
      if (ty[i] == 3'h4 || ty[i] == 3'h6)
        e_len = 32'h3 + 32'(i);
      rd(4'h0, {32'h0, 1'b1, 19'h0, (i != 1), ty[i], 8'h40 + 8'(i)});
      rd(4'h1, {32'h0, e_err});
      rd(4'h2, {32'h0, e_len});
      chk(64'(event_valid_o), 64'h1);
    end
    ex(6'h00);
    rd(4'h0, 64'h0);
    rd(4'h1, {32'h0, e_err});
    chk(64'(event_valid_o), 64'h0);
    insn_len_i <= 4'hF;
    ex(6'h10);
    rd(4'h2, 64'hF);
    io_regs_i <= ior;
    for (i = 0; i < 3; i++)
    begin
      lin_addr_i <= 64'h0123_4567_89AB_CD00 + 64'(i);
      ex(6'h04 >> i);
      rd(4'h3, 64'h0123_4567_89AB_CD00 + 64'(i));
    end
    io_regs_i <= ~ior;
    lin_addr_i <= 64'h0;
    ex(6'h10);
    rd(4'h3, 64'h0123_4567_89AB_CD02);
    for (i = 0; i < 4; i++)
      rd(4'h5 + 4'(i), ior[255 - 64 * i -: 64]);
    operand_i <= {2'h3, 4'h9, 3'h2, 1'b1, 3'h3, 4'h6, 1'b1, 4'hA, 1'b1, 4'hC};
    for (i = 0; i < 6; i++)
    begin
      virt_insn_i <= vxi_virt_insn_t'(i[2:0]);
      ex(6'h08);
      rd(4'h4, (i == 3 || i == 4) ? 64'hC000_0448 : 64'h0841_8100);
    end
    operand_i <= {2'h2, 4'h5, 3'h1, 1'b0, 3'h5, 4'h3, 1'b0, 4'hB, 1'b0, 4'h7};
    virt_insn_i <= VXI_INSN_FIELD_READ;
    ex(6'h08);
    rd(4'h4, 64'h758E_8082);
    err_code_i <= 32'hDEAD_0007;
    err_report_i <= 1'b1;
    @(posedge clk_sys_i);
    err_report_i <= 1'b0;
    rd(4'h9, 64'hDEAD_0007);
    err_code_i <= 32'h0BAD_0001;
    ex(6'h3F);
    rd(4'h9, 64'hDEAD_0007);
    for (i = 0; i < 10; i++)
      wr(i[3:0]);
    rd(4'h4, 64'h758E_8082);
    rd(4'h9, 64'hDEAD_0007);
    summarize();
  end
endmodule : vxi_exit_info_tb_top

`default_nettype wire
